// >>> design/sysctl_interrupt_status_mask.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// [R1] raw status bits set only by hardware; software writes there are ignored
// [R2] bit 6 sets when the pll ready timer reports lock
// [R3] bit 5 sets when the regulator current-limit output asserts
// [R4] bit 4 sets on internal oscillator fault
// [R5] bit 3 sets on main oscillator fault
// [R6] bit 2 sets when the regulator output is unregulated
// [R7] bit 1 sets on any brown-out and is the raw brown-out flag
// [R8] brown-out interrupts only with mask set and reset-select clear
// [R9] bit 0 sets when the pll stops oscillating
// [R10] bits 31:7 reserved, read zero; raw and mask reset to zero
// [R11] mask bit 6 gates the pll-lock interrupt
// [R12] mask bit 5 gates the current-limit interrupt
// [R13] mask bit 4 gates the internal oscillator fault interrupt
// [R14] mask bit 3 gates the main oscillator fault interrupt
// [R15] mask bit 2 gates the regulator-unregulated interrupt
// [R16] mask bit 1 gates the brown-out interrupt
// [R17] mask bit 0 gates the pll fault interrupt
// [R18] reset-select set turns a brown-out into a reset request instead
// [R19] masked status reads raw and mask; write one clears it and raw
// [R20] one interrupt line, high while any enabled raw bit is set
module sysctl_interrupt_status_mask (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst_n,
  // register port
  input  wire sysctl_irq_pkg::bus_req_t          bus_req,
  output logic       [sysctl_irq_pkg::DATA_W-1:0] bus_rdata,
  // event sources, asynchronous to mclk
  input  wire logic                              pll_lock_evt,
  input  wire logic                              current_limit_evt,
  input  wire logic                              int_osc_fault_evt,
  input  wire logic                              main_osc_fault_evt,
  input  wire logic                              regulator_unreg_evt,
  input  wire logic                              brownout_evt,
  input  wire logic                              pll_fault_evt,
  // requests to the processor
  output logic                                   irq,
  output logic                                   brownout_reset_req
);

  // ----------------------------------------------------------------
  // source synchronisers
  // ----------------------------------------------------------------
  logic [sysctl_irq_pkg::NUM_SRC-1:0] src_async;
  logic [sysctl_irq_pkg::NUM_SRC-1:0] src_meta_ff;
  logic [sysctl_irq_pkg::NUM_SRC-1:0] src_sync_ff;

  always_comb begin
    src_async = '0;
    src_async[sysctl_irq_pkg::BIT_PLL_LOCK]      = pll_lock_evt;        // R2
    src_async[sysctl_irq_pkg::BIT_CURRENT_LIMIT] = current_limit_evt;   // R3
    src_async[sysctl_irq_pkg::BIT_INT_OSC]       = int_osc_fault_evt;   // R4
    src_async[sysctl_irq_pkg::BIT_MAIN_OSC]      = main_osc_fault_evt;  // R5
    src_async[sysctl_irq_pkg::BIT_REG_UNREG]     = regulator_unreg_evt; // R6
    src_async[sysctl_irq_pkg::BIT_BROWNOUT]      = brownout_evt;        // R7
    src_async[sysctl_irq_pkg::BIT_PLL_FAULT]     = pll_fault_evt;       // R9
  end

  // sources are levels; the second stage alone feeds the status logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_meta_ff <= sysctl_irq_pkg::SRC_RESET;
      src_sync_ff <= sysctl_irq_pkg::SRC_RESET;
    end else begin
      src_meta_ff <= src_async;
      src_sync_ff <= src_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sysctl_irq_pkg::state_t state_ff;
  sysctl_irq_pkg::state_t nxt_state;
  logic [sysctl_irq_pkg::NUM_SRC-1:0] clr;
  logic [sysctl_irq_pkg::NUM_SRC-1:0] masked;
  logic [sysctl_irq_pkg::NUM_SRC-1:0] gate;

  always_comb begin
    nxt_state = state_ff;
    clr       = '0;
    nxt_state.rdata = sysctl_irq_pkg::RD_ZERO; // R10
    // write one to the masked view clears the raw bit
    if (bus_req.wr && bus_req.addr == sysctl_irq_pkg::OFS_MASKED_CLEAR) begin
      clr = bus_req.wdata[sysctl_irq_pkg::NUM_SRC-1:0] & masked; // R19
    end
    // a new event in the clearing cycle wins over the clear
    nxt_state.raw = (state_ff.raw & ~clr) | src_sync_ff; // R1
    if (bus_req.wr && bus_req.addr == sysctl_irq_pkg::OFS_MASK) begin
      nxt_state.mask = bus_req.wdata[sysctl_irq_pkg::NUM_SRC-1:0]; // R11
    end
    if (bus_req.wr && bus_req.addr == sysctl_irq_pkg::OFS_BROWNOUT_CTL) begin
      nxt_state.reset_select = bus_req.wdata[sysctl_irq_pkg::BIT_RESET_SELECT]; // R18
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        sysctl_irq_pkg::OFS_RAW_STATUS:
          nxt_state.rdata[sysctl_irq_pkg::NUM_SRC-1:0] = state_ff.raw;
        sysctl_irq_pkg::OFS_MASK:
          nxt_state.rdata[sysctl_irq_pkg::NUM_SRC-1:0] = state_ff.mask;
        sysctl_irq_pkg::OFS_MASKED_CLEAR:
          nxt_state.rdata[sysctl_irq_pkg::NUM_SRC-1:0] = masked; // R19
        sysctl_irq_pkg::OFS_BROWNOUT_CTL:
          nxt_state.rdata[sysctl_irq_pkg::BIT_RESET_SELECT] = state_ff.reset_select;
        default:
          nxt_state.rdata = sysctl_irq_pkg::RD_ZERO;
      endcase
    end
    nxt_state.irq = |(nxt_state.raw & gate); // R20
    nxt_state.bor_reset = nxt_state.raw[sysctl_irq_pkg::BIT_BROWNOUT] & nxt_state.reset_select; // R18
  end

  // brown-out mask only counts while reset-select is clear
  always_comb begin
    gate = state_ff.mask; // R11 R12 R13 R14 R15 R16 R17
    if (bus_req.wr && bus_req.addr == sysctl_irq_pkg::OFS_MASK) begin
      gate = bus_req.wdata[sysctl_irq_pkg::NUM_SRC-1:0];
    end
    if (nxt_state.reset_select) begin
      gate[sysctl_irq_pkg::BIT_BROWNOUT] = 1'b0; // R8
    end
    // the masked view is plain raw-and-mask, so a brown-out latched in reset mode stays clearable
    masked = state_ff.raw & state_ff.mask; // R19
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff.raw          <= sysctl_irq_pkg::SRC_RESET; // R10
      state_ff.mask         <= sysctl_irq_pkg::SRC_RESET; // R10
      state_ff.reset_select <= 1'b0;
      state_ff.rdata        <= sysctl_irq_pkg::RD_ZERO;
      state_ff.irq          <= 1'b0;
      state_ff.bor_reset    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata          = state_ff.rdata;
  assign irq                = state_ff.irq;
  assign brownout_reset_req = state_ff.bor_reset;

endmodule : sysctl_interrupt_status_mask

// >>> pkg/sysctl_irq_pkg.sv
package sysctl_irq_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 7;

  localparam logic [ADDR_W-1:0] OFS_RAW_STATUS   = 12'h050;
  localparam logic [ADDR_W-1:0] OFS_MASK         = 12'h054;
  localparam logic [ADDR_W-1:0] OFS_MASKED_CLEAR = 12'h058;
  localparam logic [ADDR_W-1:0] OFS_BROWNOUT_CTL = 12'h030;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_PLL_FAULT     = 0;
  localparam int BIT_BROWNOUT      = 1;
  localparam int BIT_REG_UNREG     = 2;
  localparam int BIT_MAIN_OSC      = 3;
  localparam int BIT_INT_OSC       = 4;
  localparam int BIT_CURRENT_LIMIT = 5;
  localparam int BIT_PLL_LOCK      = 6;
  localparam int BIT_RESET_SELECT  = 1;

  localparam logic [NUM_SRC-1:0] SRC_RESET = 7'h00;
  localparam logic [DATA_W-1:0]  RD_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] mask;
    logic               reset_select;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
    logic               bor_reset;
  } state_t;

endpackage : sysctl_irq_pkg

// >>> testbench/event_src_model.sv
`timescale 1ns/1ps
module event_src_model (
  // clock and requests
  input  wire logic       mclk,
  input  wire logic [6:0] want,
  // monitor outputs
  output logic      [6:0] evt
);
  // monitors answer a cycle late, like slow comparators
  initial evt = 7'h00;
  always @(posedge mclk) evt <= want;
endmodule : event_src_model

// >>> testbench/sysctl_irq_assertions.sv
`timescale 1ns/1ps
module sysctl_irq_assertions (
  // clock and bus
  input wire logic                     mclk, rst_n,
  input wire sysctl_irq_pkg::bus_req_t bus_req,
  input wire logic [31:0]              bus_rdata,
  // events and requests
  input wire logic pll_lock_evt, current_limit_evt, int_osc_fault_evt, main_osc_fault_evt,
  input wire logic regulator_unreg_evt, brownout_evt, pll_fault_evt, irq, brownout_reset_req
);
  wire logic [6:0] evts = {pll_lock_evt, current_limit_evt, int_osc_fault_evt, main_osc_fault_evt,
                           regulator_unreg_evt, brownout_evt, pll_fault_evt};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0) else $error("rdata");
  chk_rsv_bits: assert property ($past(bus_req.rd) |-> bus_rdata[31:7] == 25'h0) else $error("rsv");
  chk_rd_once: assert property (bus_req.rd ##1 !bus_req.rd |=> bus_rdata == 32'h0) else $error("rd");
  chk_rst_quiet: assert property (disable iff (1'b0) !rst_n |=> !irq && !brownout_reset_req) else $error("rst");
  chk_irq_rise: assert property ($rose(irq) |-> $past(evts, 3) != 7'h0 || $past(bus_req.wr)) else $error("irq");
  chk_irq_fall: assert property ($fell(irq) |-> $past(bus_req.wr) || !$past(rst_n)) else $error("irq");
  chk_bor_rise: assert property ($rose(brownout_reset_req) |-> $past(brownout_evt, 3) || $past(bus_req.wr)) else $error("bor");
  chk_bor_fall: assert property ($fell(brownout_reset_req) |-> $past(bus_req.wr) || !$past(rst_n)) else $error("bor");
  c_irq: cover property ($rose(irq));
  c_bor: cover property ($rose(brownout_reset_req));
  c_clr: cover property (bus_req.wr && bus_req.addr == sysctl_irq_pkg::OFS_MASKED_CLEAR && irq);
endmodule : sysctl_irq_assertions

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                     mclk, rst_n, irq, bor_req, rsel;
  sysctl_irq_pkg::bus_req_t bus_req;
  logic [31:0]              bus_rdata, v;
  logic [6:0]               want, evt, raw, msk;
  int                       miscompares, checks, cyc;
  logic [11:0] ofs [5] = '{sysctl_irq_pkg::OFS_RAW_STATUS, sysctl_irq_pkg::OFS_MASK,
    sysctl_irq_pkg::OFS_MASKED_CLEAR, sysctl_irq_pkg::OFS_BROWNOUT_CTL, 12'hFFC};
  sysctl_interrupt_status_mask u_dut (.mclk, .rst_n, .bus_req, .bus_rdata, .pll_lock_evt(evt[6]),
    .current_limit_evt(evt[5]), .int_osc_fault_evt(evt[4]), .main_osc_fault_evt(evt[3]),
    .regulator_unreg_evt(evt[2]), .brownout_evt(evt[1]), .pll_fault_evt(evt[0]), .irq,
    .brownout_reset_req(bor_req));
  event_src_model u_src (.mclk, .want, .evt);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : cmp
  // one write or read; v holds the read data of the cycle after the strobe
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
    #1 v = bus_rdata;
  endtask : bus
  function automatic logic [6:0] en();
    return raw & msk & ~{5'h00, rsel, 1'b0};
  endfunction : en
  task automatic step(input logic [6:0] m, input logic [6:0] e, input logic [6:0] c);
    bus(1'b1, sysctl_irq_pkg::OFS_MASK, {25'h0, m});
    msk = m;
    want <= e;
    repeat (2) @(posedge mclk);
    want <= 7'h00;
    repeat (4) @(posedge mclk);
    raw = raw | e;
    #1 cmp("irq", 32'(irq), 32'(|en()));
    cmp("bor", 32'(bor_req), 32'(raw[1] & rsel));
    bus(1'b1, sysctl_irq_pkg::OFS_RAW_STATUS, 32'h7F);
    bus(1'b0, sysctl_irq_pkg::OFS_RAW_STATUS, 32'h0);
    cmp("raw", v, 32'(raw));
    bus(1'b0, sysctl_irq_pkg::OFS_MASK, 32'h0);
    cmp("mask", v, 32'(msk));
    bus(1'b0, sysctl_irq_pkg::OFS_MASKED_CLEAR, 32'h0);
    cmp("masked", v, 32'(raw & msk));
    bus(1'b1, sysctl_irq_pkg::OFS_MASKED_CLEAR, 32'(c));
    raw = raw & ~(c & msk);
    cmp("irq clr", 32'(irq), 32'(|en()));
    bus(1'b0, sysctl_irq_pkg::OFS_RAW_STATUS, 32'h0);
    cmp("raw clr", v, 32'(raw));
  endtask : step
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    want = 7'h00;
    {raw, msk, rsel} = '0;
    void'($urandom(32'h58FB2F1C));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (ofs[k]) begin
      bus(1'b0, ofs[k], 32'h0);
      cmp("reset", v, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      step(7'h00, 7'(1 << i), 7'(1 << i));
      step(7'(1 << i), 7'h00, 7'(1 << i));
    end
    bus(1'b1, sysctl_irq_pkg::OFS_BROWNOUT_CTL, 32'h2);
    rsel = 1'b1;
    step(7'h02, 7'h02, 7'h02);
    $display("test directed done");
    repeat (30) begin
      rsel = 1'($urandom);
      bus(1'b1, sysctl_irq_pkg::OFS_BROWNOUT_CTL, {30'h0, rsel, 1'b0});
      step(7'($urandom), 7'($urandom), 7'($urandom));
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule : testbench
bind sysctl_interrupt_status_mask sysctl_irq_assertions u_chk (.mclk, .rst_n, .bus_req, .bus_rdata,
  .pll_lock_evt, .current_limit_evt, .int_osc_fault_evt, .main_osc_fault_evt, .regulator_unreg_evt,
  .brownout_evt, .pll_fault_evt, .irq, .brownout_reset_req);
